// ### shared/scs_params.svh
`ifndef SCS_PARAMS_SVH
`define SCS_PARAMS_SVH
// Register addresses
`define SCS_A_TRQ_SCALE 16'h2210
`define SCS_A_TRQ_OFS 16'h2211
`define SCS_A_TRQ_CLAMP 16'h2212
`define SCS_A_TRQ_FILT 16'h2213
`define SCS_A_VEL_SCALE 16'h2214
`define SCS_A_VEL_OFS 16'h2215
`define SCS_A_VEL_CLAMP 16'h2216
`define SCS_A_VEL_FILT 16'h2217
`define SCS_A_LIM_SEL 16'h230d
`define SCS_A_TM_LIM 16'h230e
`define SCS_A_CTL_MODE 16'h3000
`define SCS_A_VSRC 16'h231a
`define SCS_A_TLF 16'h2110
`define SCS_A_PRESET0 16'h2312
`define SCS_A_SPD_COMM 16'h2f00
`define SCS_A_STATUS 16'h2f01
// Reset values
`define SCS_RST_TRQ_SCALE 16'h0064
`define SCS_RST_TM_LIM 16'h03e8
`define SCS_RST_ZERO 16'h0000
// Misc constants
`define SCS_TLF_ANALOG 16'h0004
`define SCS_MV_PER_V 34'sh0_0000_03e8
`define SCS_MOTOR_MAX_RPM 16'h1770
`define SCS_NUM_PRESET 8
`endif

// ### shared/scs_pkg.sv
package scs_pkg;
  typedef enum logic [1:0] {
    MODE_INDEX = 2'b00,
    MODE_PULSE = 2'b01,
    MODE_VEL = 2'b10,
    MODE_TRQ = 2'b11
  } scs_mode_t;

  typedef enum logic [15:0] {
    CM_INDEX = 16'h0000,
    CM_PULSE = 16'h0001,
    CM_VEL = 16'h0002,
    CM_TRQ = 16'h0003,
    CM_PULSE_INDEX = 16'h0004,
    CM_PULSE_VEL = 16'h0005,
    CM_PULSE_TRQ = 16'h0006,
    CM_VEL_TRQ = 16'h0007,
    CM_INDEX_VEL = 16'h0008,
    CM_INDEX_TRQ = 16'h0009
  } scs_cm_t;

  typedef enum logic [15:0] {
    VSRC_ANALOG = 16'h0000,
    VSRC_TWO_BIT = 16'h0001,
    VSRC_THREE_BIT = 16'h0002,
    VSRC_PRESET = 16'h0003
  } scs_vsrc_t;

  typedef struct packed {
    logic [15:0] trq_scale;
    logic [15:0] trq_ofs;
    logic [15:0] trq_clamp;
    logic [15:0] trq_filt;
    logic [15:0] vel_scale;
    logic [15:0] vel_ofs;
    logic [15:0] vel_clamp;
    logic [15:0] vel_filt;
    logic [15:0] lim_sel;
    logic [15:0] tm_lim;
    logic [15:0] ctl_mode;
    logic [15:0] vsrc;
    logic [15:0] tlf;
    logic [2:0] spd_comm;
    logic [7:0][15:0] preset;
    scs_mode_t mode;
    logic [2:0] spd;
    logic signed [31:0] vel_cmd;
    logic signed [31:0] trq_cmd;
    logic [15:0] spd_lim;
    logic [31:0] trq_lim;
    logic trq_lim_en;
    logic [15:0] rdata;
  } scs_state_t;
endpackage

// ### sim/scs_contact_model.sv
`timescale 1ns/1ps
module scs_contact_model (
  // Clock
  input wire logic clk,
  // Requested levels
  input wire logic [2:0] spd_req,
  input wire logic mode_req,
  // Contact pins
  output logic speed_select_bit0,
  output logic speed_select_bit1,
  output logic speed_select_bit2,
  output logic mode_in
);
  // Host outputs move just after an edge
  always @(posedge clk) begin
    {speed_select_bit2, speed_select_bit1, speed_select_bit0} <= spd_req;
    mode_in <= mode_req;
  end
endmodule

// ### sim/scs_top_asserts.sv
`timescale 1ns/1ps
module scs_top_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Contacts and analog
  input wire logic mode_in,
  input wire logic speed_select_bit0,
  input wire logic speed_select_bit1,
  input wire logic speed_select_bit2,
  input wire logic signed [15:0] analog_velocity_mv,
  input wire logic signed [15:0] analog_torque_mv,
  // Commands
  input wire scs_pkg::scs_mode_t active_mode,
  input wire logic signed [31:0] velocity_command,
  input wire logic signed [31:0] torque_command,
  input wire logic [15:0] speed_limit,
  input wire logic [31:0] torque_limit,
  input wire logic torque_limit_en
);
  logic [35:0] in_q;
  logic [3:0] quiet_q;
  logic [1:0] seen_q;
  wire [35:0] in_now = {mode_in, speed_select_bit2, speed_select_bit1, speed_select_bit0,
    analog_velocity_mv, analog_torque_mv};

  // Cycles since the last write or input change
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_q <= '0;
      quiet_q <= 4'h0;
      seen_q <= 2'h0;
    end else begin
      in_q <= in_now;
      if (reg_wr || in_now != in_q) quiet_q <= 4'h0;
      else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
      if (reg_wr && reg_addr == 16'h2210) seen_q[0] <= 1'b1;
      if (reg_wr && reg_addr == 16'h230e) seen_q[1] <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_rd(logic [15:0] a);
    reg_rd && reg_addr == a;
  endsequence
  sequence s_not_trq;
    (active_mode != scs_pkg::MODE_TRQ) [*2];
  endsequence
  sequence s_trq;
    (active_mode == scs_pkg::MODE_TRQ) [*2];
  endsequence

  property p_scale_init;
    s_rd(16'h2210) ##0 !seen_q[0] |=> reg_rdata == 16'h0064;
  endproperty
  a_scale_init: assert property (p_scale_init) else $error("scale reset value wrong");
  property p_tm_lim_init;
    s_rd(16'h230e) ##0 !seen_q[1] |=> reg_rdata == 16'h03e8;
  endproperty
  a_tm_lim_init: assert property (p_tm_lim_init) else $error("speed limit reset wrong");
  property p_trq_off;
    s_not_trq |-> torque_command == 32'sh0;
  endproperty
  a_trq_off: assert property (p_trq_off) else $error("torque command outside torque");
  property p_lim_en_off;
    s_trq |-> !torque_limit_en;
  endproperty
  a_lim_en_off: assert property (p_lim_en_off) else $error("limit enabled in torque");
  property p_lim_zero;
    !torque_limit_en |-> torque_limit == 32'h0;
  endproperty
  a_lim_zero: assert property (p_lim_zero) else $error("limit value while disabled");
  property p_spd_max;
    s_not_trq |-> speed_limit == 16'h1770;
  endproperty
  a_spd_max: assert property (p_spd_max) else $error("speed cap outside torque");
  property p_mode_hold;
    quiet_q >= 4'h5 |=> $stable(active_mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode moved without cause");
  property p_cmd_hold;
    quiet_q >= 4'h6 |-> $stable(velocity_command) && $stable(torque_command);
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command moved without cause");
endmodule

bind scs_top scs_top_asserts u_scs_top_asserts (.*);

// ### sim/servo_command_source_select_bench.sv
`timescale 1ns/1ps
module servo_command_source_select_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] reg_addr = 16'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata, spd_lim, got;
  logic b0, b1, b2, mode_in, trq_lim_en;
  logic [2:0] spd_req = 3'h0;
  logic mode_req = 1'b0;
  logic signed [15:0] vel_mv = 16'sh0;
  logic signed [15:0] trq_mv = 16'sh0;
  scs_pkg::scs_mode_t active_mode;
  logic signed [31:0] vel_cmd, trq_cmd;
  logic [31:0] trq_lim;
  logic [15:0] preset [8];
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  int seed = 32'h8f81dd69;
  int bas [10] = '{0, 1, 2, 3, 1, 1, 1, 2, 0, 0};
  int alt [10] = '{0, 1, 2, 3, 0, 2, 3, 3, 2, 3};

  always #12.5 clk = ~clk;

  scs_top u_scs_top (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode_in(mode_in),
    .speed_select_bit0(b0), .speed_select_bit1(b1), .speed_select_bit2(b2),
    .analog_velocity_mv(vel_mv), .analog_torque_mv(trq_mv), .active_mode(active_mode),
    .velocity_command(vel_cmd), .torque_command(trq_cmd), .speed_limit(spd_lim),
    .torque_limit(trq_lim), .torque_limit_en(trq_lim_en));
  scs_contact_model u_scs_contact_model (.clk(clk), .spd_req(spd_req), .mode_req(mode_req),
    .speed_select_bit0(b0), .speed_select_bit1(b1), .speed_select_bit2(b2),
    .mode_in(mode_in));

  task automatic close_out();
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  function automatic int ana(int raw, int scl, int clamp);
    if (raw < clamp && -raw < clamp) return 0;
    return raw * scl / 1000;
  endfunction

  function automatic int exp_vel(int src, int code, int a);
    if (src == 1) return (code % 4 == 3) ? a : preset[code % 4];
    if (src == 2) return (code == 7) ? a : preset[code];
    if (src == 3) return preset[code];
    return a;
  endfunction

  initial begin
    int scl, a, t, lim, em;
    logic link;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(16'h2210, got);
    chk(got, 32'h64);
    rd(16'h230e, got);
    chk(got, 32'h3e8);
    rd(16'h1234, got);
    chk(got, 32'h0);
    chk(active_mode, 32'h0);
    $display("reset test done");
    wr(16'h3000, 16'h2);
    wr(16'h2216, 16'h32);
    for (int k = 0; k < 8; k++) begin
      preset[k] = 16'($random(seed)) & 16'h3fff;
      wr(16'h2312 + 16'(k), preset[k]);
    end
    for (int src = 0; src < 4; src++) begin
      wr(16'h231a, 16'(src));
      for (int code = 0; code < 8; code++) begin
        scl = $random(seed) % 3000;
        a = (code == 6) ? 20 : $random(seed) % 10000;
        link = 1'($random(seed));
        wr(16'h2214, 16'(scl));
        wr(16'h2f00, link ? 16'(code) : 16'h0);
        spd_req <= link ? 3'h0 : 3'(code);
        vel_mv <= 16'(a);
        repeat (8) @(posedge clk);
        @(negedge clk);
        chk(vel_cmd, exp_vel(src, code, ana(a, scl, 50)));
      end
    end
    $display("velocity test done");
    wr(16'h2110, 16'h4);
    wr(16'h2210, 16'h190);
    for (int cm = 0; cm < 10; cm++) begin
      for (int m = 0; m < 2; m++) begin
        a = $random(seed) % 10000;
        lim = $random(seed) & 32'h7fff;
        wr(16'h3000, 16'(cm));
        wr(16'h230d, 16'(cm % 2));
        wr(16'h230e, 16'(lim));
        mode_req <= m[0];
        trq_mv <= 16'(a);
        repeat (8) @(posedge clk);
        @(negedge clk);
        em = m ? alt[cm] : bas[cm];
        t = ana(a, 400, 0);
        chk(active_mode, em);
        if (em == 3) begin
          chk(trq_cmd, t);
          chk(spd_lim, (cm % 2) ? 32'h1770 : lim);
        end else begin
          chk(trq_lim_en, 32'h1);
          chk(trq_lim, t < 0 ? -t : t);
        end
        // Status: limit enable, select code left at 7, mode
        rd(16'h2f01, got);
        chk(got, {(em != 3), 3'h7, 2'(em)});
      end
    end
    // Unknown control setting keeps torque operation
    wr(16'h3000, 16'ha);
    mode_req <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk(active_mode, 32'h3);
    $display("mode test done");
    close_out();
  end
endmodule

// ### src/scs_scale.sv
`timescale 1ns/1ps
`include "scs_params.svh"
module scs_scale (
  // Sample and settings
  input wire logic signed [15:0] raw_mv,
  input wire logic signed [15:0] ofs_mv,
  input wire logic signed [15:0] scale,
  input wire logic [15:0] clamp_mv,
  // Scaled result
  output logic signed [31:0] result
);
  logic signed [16:0] adj;
  logic [16:0] mag;
  logic signed [33:0] prod;
  logic signed [33:0] quot;

  always_comb begin
    adj = 17'(raw_mv) - 17'(ofs_mv);
    mag = adj[16] ? 17'(-adj) : adj;
    prod = 34'(adj) * 34'(scale);
    quot = prod / `SCS_MV_PER_V;
    // Residual offset below clamp reads as zero
    if (mag < {1'b0, clamp_mv}) begin
      result = '0;
    end else begin
      result = quot[31:0];
    end
  end
endmodule

// ### src/scs_sync.sv
`timescale 1ns/1ps
module scs_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule

// ### src/scs_top.sv
`timescale 1ns/1ps
`include "scs_params.svh"
module scs_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Contact inputs
  input wire logic mode_in,
  input wire logic speed_select_bit0,
  input wire logic speed_select_bit1,
  input wire logic speed_select_bit2,
  // Digitised analog inputs, millivolts
  input wire logic signed [15:0] analog_velocity_mv,
  input wire logic signed [15:0] analog_torque_mv,
  // Commands out
  output scs_pkg::scs_mode_t active_mode,
  output logic signed [31:0] velocity_command,
  output logic signed [31:0] torque_command,
  output logic [15:0] speed_limit,
  output logic [31:0] torque_limit,
  output logic torque_limit_en
);
  scs_pkg::scs_state_t s_q;
  scs_pkg::scs_state_t s_d;

  logic [3:0] pins_sync;
  logic signed [31:0] vel_analog;
  logic signed [31:0] trq_analog;
  logic [2:0] spd_now;
  logic [31:0] trq_mag;

  // Mode and speed selects into the clock domain
  scs_sync #(
    .W(4)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .din({mode_in, speed_select_bit2, speed_select_bit1, speed_select_bit0}),
    .dout(pins_sync)
  );

  // Analog velocity path
  scs_scale u_vel_scale (
    .raw_mv(analog_velocity_mv),
    .ofs_mv(s_q.vel_ofs),
    .scale(s_q.vel_scale),
    .clamp_mv(s_q.vel_clamp),
    .result(vel_analog)
  );

  // Analog torque path
  scs_scale u_trq_scale (
    .raw_mv(analog_torque_mv),
    .ofs_mv(s_q.trq_ofs),
    .scale(s_q.trq_scale),
    .clamp_mv(s_q.trq_clamp),
    .result(trq_analog)
  );

  // Operating mode from setting and mode input
  function automatic scs_pkg::scs_mode_t mode_pick(
    input logic [15:0] cm,
    input logic alt,
    input scs_pkg::scs_mode_t hold
  );
    scs_pkg::scs_mode_t m;
    m = hold;
    case (cm)
      scs_pkg::CM_INDEX: begin
        m = scs_pkg::MODE_INDEX;
      end
      scs_pkg::CM_PULSE: begin
        m = scs_pkg::MODE_PULSE;
      end
      scs_pkg::CM_VEL: begin
        m = scs_pkg::MODE_VEL;
      end
      scs_pkg::CM_TRQ: begin
        m = scs_pkg::MODE_TRQ;
      end
      scs_pkg::CM_PULSE_INDEX: begin
        m = alt ? scs_pkg::MODE_INDEX : scs_pkg::MODE_PULSE;
      end
      scs_pkg::CM_PULSE_VEL: begin
        m = alt ? scs_pkg::MODE_VEL : scs_pkg::MODE_PULSE;
      end
      scs_pkg::CM_PULSE_TRQ: begin
        m = alt ? scs_pkg::MODE_TRQ : scs_pkg::MODE_PULSE;
      end
      scs_pkg::CM_VEL_TRQ: begin
        m = alt ? scs_pkg::MODE_TRQ : scs_pkg::MODE_VEL;
      end
      scs_pkg::CM_INDEX_VEL: begin
        m = alt ? scs_pkg::MODE_VEL : scs_pkg::MODE_INDEX;
      end
      scs_pkg::CM_INDEX_TRQ: begin
        m = alt ? scs_pkg::MODE_TRQ : scs_pkg::MODE_INDEX;
      end
      default: begin
        m = hold;
      end
    endcase
    return m;
  endfunction

  // Preset slot hit for an address
  function automatic logic preset_hit(
    input logic [15:0] addr,
    input int idx
  );
    return addr == 16'(`SCS_A_PRESET0 + idx);
  endfunction

  // Velocity source choice
  function automatic logic signed [31:0] vel_pick(
    input logic [15:0] src,
    input logic [2:0] spd,
    input logic [7:0][15:0] preset,
    input logic signed [31:0] analog
  );
    logic signed [31:0] v;
    v = analog;
    case (src)
      scs_pkg::VSRC_ANALOG: begin
        v = analog;
      end
      scs_pkg::VSRC_TWO_BIT: begin
        if (spd[1:0] == 2'h3) begin
          v = analog;
        end else begin
          v = 32'(signed'(preset[{1'b0, spd[1:0]}]));
        end
      end
      scs_pkg::VSRC_THREE_BIT: begin
        if (spd == 3'h7) begin
          v = analog;
        end else begin
          v = 32'(signed'(preset[spd]));
        end
      end
      scs_pkg::VSRC_PRESET: begin
        v = 32'(signed'(preset[spd]));
      end
      default: begin
        v = analog;
      end
    endcase
    return v;
  endfunction

  always_comb begin
    // Pin or link may drive each select
    spd_now = pins_sync[2:0] | s_q.spd_comm;
    trq_mag = trq_analog[31] ? 32'(-trq_analog) : 32'(trq_analog);
  end

  always_comb begin
    s_d = s_q;
    s_d.rdata = '0;

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        `SCS_A_TRQ_SCALE: begin
          s_d.trq_scale = reg_wdata;
        end
        `SCS_A_TRQ_OFS: begin
          s_d.trq_ofs = reg_wdata;
        end
        `SCS_A_TRQ_CLAMP: begin
          s_d.trq_clamp = reg_wdata;
        end
        `SCS_A_TRQ_FILT: begin
          s_d.trq_filt = reg_wdata;
        end
        `SCS_A_VEL_SCALE: begin
          s_d.vel_scale = reg_wdata;
        end
        `SCS_A_VEL_OFS: begin
          s_d.vel_ofs = reg_wdata;
        end
        `SCS_A_VEL_CLAMP: begin
          s_d.vel_clamp = reg_wdata;
        end
        `SCS_A_VEL_FILT: begin
          s_d.vel_filt = reg_wdata;
        end
        `SCS_A_LIM_SEL: begin
          s_d.lim_sel = reg_wdata;
        end
        `SCS_A_TM_LIM: begin
          s_d.tm_lim = reg_wdata;
        end
        `SCS_A_CTL_MODE: begin
          s_d.ctl_mode = reg_wdata;
        end
        `SCS_A_VSRC: begin
          s_d.vsrc = reg_wdata;
        end
        `SCS_A_TLF: begin
          s_d.tlf = reg_wdata;
        end
        `SCS_A_SPD_COMM: begin
          s_d.spd_comm = reg_wdata[2:0];
        end
        default: begin
          for (int i = 0; i < `SCS_NUM_PRESET; i++) begin
            if (preset_hit(reg_addr, i)) begin
              s_d.preset[i] = reg_wdata;
            end
          end
        end
      endcase
    end

    // Register reads, data in the following cycle
    if (reg_rd) begin
      case (reg_addr)
        `SCS_A_TRQ_SCALE: begin
          s_d.rdata = s_q.trq_scale;
        end
        `SCS_A_TRQ_OFS: begin
          s_d.rdata = s_q.trq_ofs;
        end
        `SCS_A_TRQ_CLAMP: begin
          s_d.rdata = s_q.trq_clamp;
        end
        `SCS_A_TRQ_FILT: begin
          s_d.rdata = s_q.trq_filt;
        end
        `SCS_A_VEL_SCALE: begin
          s_d.rdata = s_q.vel_scale;
        end
        `SCS_A_VEL_OFS: begin
          s_d.rdata = s_q.vel_ofs;
        end
        `SCS_A_VEL_CLAMP: begin
          s_d.rdata = s_q.vel_clamp;
        end
        `SCS_A_VEL_FILT: begin
          s_d.rdata = s_q.vel_filt;
        end
        `SCS_A_LIM_SEL: begin
          s_d.rdata = s_q.lim_sel;
        end
        `SCS_A_TM_LIM: begin
          s_d.rdata = s_q.tm_lim;
        end
        `SCS_A_CTL_MODE: begin
          s_d.rdata = s_q.ctl_mode;
        end
        `SCS_A_VSRC: begin
          s_d.rdata = s_q.vsrc;
        end
        `SCS_A_TLF: begin
          s_d.rdata = s_q.tlf;
        end
        `SCS_A_SPD_COMM: begin
          s_d.rdata = {13'h0000, s_q.spd_comm};
        end
        `SCS_A_STATUS: begin
          s_d.rdata = {10'h000, s_q.trq_lim_en, s_q.spd, 2'(s_q.mode)};
        end
        default: begin
          for (int i = 0; i < `SCS_NUM_PRESET; i++) begin
            if (preset_hit(reg_addr, i)) begin
              s_d.rdata = s_q.preset[i];
            end
          end
        end
      endcase
    end

    // Selection captured every cycle, applied on the next cycle
    s_d.spd = spd_now;
    s_d.mode = mode_pick(s_q.ctl_mode, pins_sync[3], s_q.mode);

    s_d.vel_cmd = vel_pick(s_q.vsrc, s_q.spd, s_q.preset, vel_analog);

    // Torque command only while in torque operation
    if (s_q.mode == scs_pkg::MODE_TRQ) begin
      s_d.trq_cmd = trq_analog;
      if (s_q.lim_sel == `SCS_RST_ZERO) begin
        s_d.spd_lim = s_q.tm_lim;
      end else begin
        s_d.spd_lim = `SCS_MOTOR_MAX_RPM;
      end
      s_d.trq_lim_en = 1'b0;
      s_d.trq_lim = '0;
    end else begin
      s_d.trq_cmd = '0;
      s_d.spd_lim = `SCS_MOTOR_MAX_RPM;
      s_d.trq_lim_en = (s_q.tlf == `SCS_TLF_ANALOG);
      s_d.trq_lim = (s_q.tlf == `SCS_TLF_ANALOG) ? trq_mag : '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.trq_scale <= `SCS_RST_TRQ_SCALE;
      s_q.tm_lim <= `SCS_RST_TM_LIM;
      s_q.mode <= scs_pkg::MODE_INDEX;
      s_q.spd_lim <= `SCS_MOTOR_MAX_RPM;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign active_mode = s_q.mode;
  assign velocity_command = s_q.vel_cmd;
  assign torque_command = s_q.trq_cmd;
  assign speed_limit = s_q.spd_lim;
  assign torque_limit = s_q.trq_lim;
  assign torque_limit_en = s_q.trq_lim_en;
endmodule
